/* lcd_decoder_checker.sv */
// Concurrent checks on the LCD instruction decoder's ports.
// Assumes one clock domain; instruction checks cover eight-bit transfers.
`timescale 1ns/10ps
module lcd_decoder_checker #(
  parameter int unsigned EXEC_CYCLES = 1
) (
  input wire logic                       clock,
  input wire logic                       srst,
  input wire logic                       clk_en,
  input wire logic                       serial_mode,
  input wire logic                       host_strobe,
  input wire lcd_decoder_pkg::host_req_s host_req,
  input wire logic [7:0]                 host_rdata,
  input wire logic                       entry_incr,
  input wire logic                       busy_flag,
  input wire logic [6:0]                 addr_counter,
  input wire lcd_decoder_pkg::func_cfg_s func_cfg,
  input wire logic                       display_on,
  input wire logic                       four_bit_mode
);
  localparam int BUSY_LEN = EXEC_CYCLES + 1;
  localparam int DONE_AT  = EXEC_CYCLES + 2;
  logic [15:0] busy_cnt;
  // Decode of an accepted write; four-bit nibbles are left out on purpose
  wire       acc   = host_strobe & ~host_req.read_n_write & ~busy_flag & clk_en & ~four_bit_mode;
  wire       ins   = acc & ~host_req.reg_select;
  wire [7:0] d     = host_req.data;
  wire [6:0] d_adr = d[6:0];
  wire [3:0] d_con = d[3:0];
  wire       d_dir = d[2];
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Length of the running busy period
  always_ff @(posedge clock) begin
    if (srst)
      busy_cnt <= 16'h0000;
    else
      busy_cnt <= busy_flag ? busy_cnt + 16'h0001 : 16'h0000;
  end
  a_busy_on_write: assert property (acc |=> busy_flag)
    else $error("busy did not rise after an accepted write");
  a_busy_run_length: assert property ($fell(busy_flag) |-> busy_cnt == BUSY_LEN)
    else $error("busy period has the wrong length");
  a_status_read: assert property (host_strobe & clk_en & host_req.read_n_write &
    ~host_req.reg_select & ~four_bit_mode |=> host_rdata == {$past(busy_flag), $past(addr_counter)})
    else $error("status read does not return busy and counter");
  a_addr_load: assert property (ins & d[7] |-> ##DONE_AT addr_counter == $past(d_adr, DONE_AT))
    else $error("address set not loaded into counter");
  a_contrast_load: assert property (ins & d[7:6] == 2'b01 |->
    ##DONE_AT func_cfg.contrast_level == $past(d_con, DONE_AT))
    else $error("contrast level not loaded");
  a_cursor_step: assert property (ins & d[7:3] == 5'b00010 |-> ##DONE_AT addr_counter ==
    ($past(d_dir, DONE_AT) ? (($past(addr_counter, DONE_AT) == 7'h0f) ? 7'h10
    : $past(addr_counter, DONE_AT) + 7'h01) : $past(addr_counter, DONE_AT) - 7'h01))
    else $error("cursor shift stepped counter wrongly");
  a_display_keeps_ac: assert property (ins & d[7:3] == 5'b00011 |->
    ##DONE_AT addr_counter == $past(addr_counter, DONE_AT))
    else $error("display shift changed the counter");
  a_data_write_step: assert property (acc & host_req.reg_select |-> ##DONE_AT addr_counter ==
    ($past(entry_incr, DONE_AT) ? (($past(addr_counter, DONE_AT) == 7'h0f) ? 7'h10
    : $past(addr_counter, DONE_AT) + 7'h01) : $past(addr_counter, DONE_AT) - 7'h01))
    else $error("data write did not step the counter");
  a_powerdown_dark: assert property (ins & d[7:5] == 3'b001 & ~d[0] |->
    ##DONE_AT !display_on && !func_cfg.powerdown_n)
    else $error("powerdown left the display on");
  a_width_mode: assert property (four_bit_mode == (!func_cfg.bus_width_sel && !serial_mode))
    else $error("four bit mode does not follow width select");
  c_addr_set: cover property (ins & d[7]);
  c_data_write: cover property (acc & host_req.reg_select);
  c_four_bit: cover property (four_bit_mode && host_strobe);
endmodule : lcd_decoder_checker

bind lcd_instruction_decoder lcd_decoder_checker #(.EXEC_CYCLES(EXEC_CYCLES)) i_lcd_decoder_checker (
  .clock(clock), .srst(srst), .clk_en(clk_en), .serial_mode(serial_mode),
  .host_strobe(host_strobe), .host_req(host_req), .host_rdata(host_rdata),
  .entry_incr(entry_incr), .busy_flag(busy_flag), .addr_counter(addr_counter),
  .func_cfg(func_cfg), .display_on(display_on), .four_bit_mode(four_bit_mode)
);

/* lcd_decoder_pkg.sv */
// Package for the LCD instruction decoder: opcode fields, address map,
// reset values and execution timing.
// Assumes a single 125 MHz clock domain and a synchronous active-high reset.
package lcd_decoder_pkg;

  localparam int unsigned CLOCK_MHZ     = 125;
  // Internal execution time of one instruction, in ns
  localparam int unsigned EXEC_TIME_NS  = 40;
  localparam int unsigned EXEC_CYCLES   = (EXEC_TIME_NS * CLOCK_MHZ + 999) / 1000;

  // Opcode bit positions
  localparam int unsigned ADDR_SET_BIT  = 7;
  localparam int unsigned CONTRAST_BIT  = 6;
  localparam int unsigned FUNC_SET_BIT  = 5;
  localparam int unsigned SHIFT_BIT     = 4;
  localparam int unsigned SHIFT_SC_BIT  = 3;
  localparam int unsigned SHIFT_RL_BIT  = 2;
  localparam int unsigned WIDTH_SEL_BIT = 4;
  localparam int unsigned PWR_BIT       = 0;

  // Address map boundaries (full 7-bit addresses)
  localparam logic [6:0] LINE1_LAST     = 7'h0f;
  localparam logic [6:0] LINE2_FIRST    = 7'h10;
  localparam logic [6:0] TEXT_LIMIT     = 7'h30;
  localparam logic [6:0] GLYPH_BASE     = 7'h40;
  localparam logic [6:0] ICON_BASE      = 7'h60;
  localparam int unsigned RAM_WORDS     = 128;

  // Reset values
  localparam logic       WIDTH_RESET    = 1'b1;
  localparam logic       PWR_RESET      = 1'b1;
  localparam logic [3:0] CONTRAST_RESET = 4'h0;
  localparam logic [6:0] AC_RESET       = 7'h00;
  localparam logic [5:0] SHIFT_RESET    = 6'h00;

  // One host bus cycle as seen by the decoder
  typedef struct packed {
    logic       reg_select;
    logic       read_n_write;
    logic [7:0] data;
  } host_req_s;

  // Settings kept by the decoder
  typedef struct packed {
    logic       bus_width_sel;
    logic       powerdown_n;
    logic [3:0] contrast_level;
  } func_cfg_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_DONE  = 2'b11
  } exec_state_e;

endpackage : lcd_decoder_pkg

/* lcd_host_model.sv */
// Host processor model driving bus transfers into the decoder.
// Assumes busy_flag and host_rdata settle before the falling edge.
`timescale 1ns/10ps
module lcd_host_model (
  input  wire logic                       clock,
  input  wire logic                       busy_flag,
  output      logic                       host_strobe,
  output      lcd_decoder_pkg::host_req_s host_req
);
  // Bus idle at time zero
  initial begin
    host_strobe = 1'b0;
    host_req = '0;
  end
  // One transfer; a released bus reads back inverted, never the old value
  task automatic send(input logic rs, input logic rw, input logic [7:0] d);
    @(negedge clock);
    host_strobe = 1'b1;
    host_req = '{reg_select: rs, read_n_write: rw, data: d};
    @(negedge clock);
    host_strobe = 1'b0;
    host_req = lcd_decoder_pkg::host_req_s'(~host_req);
  endtask : send
  // Poll busy until clear before the next instruction
  task automatic wait_idle();
    for (int i = 0; i < 64 && busy_flag !== 1'b0; i++) @(negedge clock);
  endtask : wait_idle
endmodule : lcd_host_model

/* lcd_instruction_decoder.sv */
// Instruction decoder for a three-line character LCD controller with
// text, glyph and icon RAM behind one shared 7-bit address counter.
// Assumes host strobes are synchronous to clock, one per bus transfer.
// Assumes the display scanner, entry-mode and display-on instructions live
// outside and reach this block as plain level or pulse ports.
`timescale 1ns/10ps

// How it works
// [RQ1] RS=0 write with top bits 0001 is shift; bit3 target, bit2 direction
// [RQ2] Cursor left/right steps counter; display left/right shifts, cursor follows
// [RQ3] Cursor passing position 16 of line one jumps to line two start
// [RQ4] Display shift moves all lines horizontally, never wrapping into line above
// [RQ5] Display-only shift leaves the address counter unchanged
// [RQ6] Opcode 001x: bit4 width select, bit0 powerdown control, width ignored serially
// [RQ7] Width 1 uses eight lines; width 0 uses four, two transfers per byte
// [RQ8] Powerdown control 1 is normal, 0 enters powerdown, character display off
// [RQ9] Entering powerdown clears display-on; it stays off until display-on command
// [RQ10] Host issues function-set first, and again only to change width
// [RQ11] Opcode 01xx loads four low bits into contrast register, higher is stronger
// [RQ12] Host writes contrast zero when contrast adjustment is unused
// [RQ13] Opcode 1xxx loads seven low bits into address counter, selecting RAM
// [RQ14] Text 00-2F, glyph 40-5F, icon 60-7F share one address space
// [RQ15] RS=0 read returns busy on bit 7 and counter on bits 6..0
// [RQ16] Busy reads 1 during execution; new instructions are not taken then
// [RQ17] Host polls busy until 0 before next instruction
// [RQ18] RS=1 write stores byte to text RAM, five bits to glyph or icon
// [RQ19] Each write steps counter by entry direction and shifts if enabled; the code shifts only on text RAM writes
// [RQ20] RS=1 read returns text byte, or five low bits from glyph or icon
// [RQ21] Host sets address before reading; first read after write is unreliable
// [RQ22] Text read steps counter by entry direction, never shifts display
// [RQ23] Entry direction 1 increments counter, 0 decrements
// [RQ24] Display off hides text but RAM keeps contents
// [RQ25] Four-bit mode sends upper nibble first on upper lines, including status
// [RQ26] Busy held from acceptance to completion; don't-care bits ignored
module lcd_instruction_decoder #(
  parameter int unsigned EXEC_CYCLES = lcd_decoder_pkg::EXEC_CYCLES
) (
  input  wire logic                        clock,
  input  wire logic                        srst,
  input  wire logic                        clk_en,
  input  wire logic                        serial_mode,
  input  wire logic                        host_strobe,
  input  wire lcd_decoder_pkg::host_req_s  host_req,
  output      logic [7:0]                  host_rdata,
  input  wire logic                        entry_incr,
  input  wire logic                        entry_shift,
  input  wire logic                        display_on_set,
  input  wire logic                        display_on_val,
  output      logic                        busy_flag,
  output      logic [6:0]                  addr_counter,
  output      lcd_decoder_pkg::func_cfg_s  func_cfg,
  output      logic                        display_on,
  output      logic [5:0]                  display_offset,
  output      logic                        four_bit_mode
);

  // The busy counter is eight bits wide, so longer execution cannot be served
  if (EXEC_CYCLES < 1 || EXEC_CYCLES > 255) begin : g_bad_exec
    $error("EXEC_CYCLES out of range");
  end

  // Shared RAM array; glyph and icon words keep only five bits
  logic [7:0]              ram_mem [lcd_decoder_pkg::RAM_WORDS];
  lcd_decoder_pkg::exec_state_e state_reg;
  logic [7:0]              exec_cnt_reg;
  logic                    nibble_phase_reg;
  logic [3:0]              nibble_hold_reg;
  logic                    rd_phase_reg;
  logic [7:0]              rd_byte_reg;
  logic [7:0]              read_latch_reg;
  logic                    pend_rs_reg;
  logic                    pend_rw_reg;
  logic [7:0]              pend_data_reg;

  // Byte assembly
  logic                    full_valid;
  logic [7:0]              full_byte;
  logic                    accept;
  logic                    is_text;
  logic [6:0]              ac_step;
  logic [6:0]              ac_up;
  logic [6:0]              ac_down;
  logic [6:0]              ac_cursor;
  logic                    apply;
  logic                    data_read_go;

  // Overview of the flow through this block:
  // A host transfer arrives as one strobe with its request struct.
  // Writes are assembled into a full byte, one or two strobes per byte.
  // An accepted byte is parked in the pending registers at once.
  // The busy sequencer then counts out the execution time.
  // All architectural updates happen together in the single DONE cycle,
  // so every register sees one consistent view of the pending opcode.
  // Reads of status never start busy; data reads do, since they step
  // the counter like a write would and also refill the read latch.
  // Trade-off: one shared apply strobe keeps the update logic simple,
  // at the price of a fixed latency even for trivial instructions.

  // Serial transfers always carry whole bytes, so the width select is moot
  assign four_bit_mode = ~func_cfg.bus_width_sel & ~serial_mode;

  // In four-bit mode the upper nibble comes first on data[7:4]
  always_comb begin
    full_valid = 1'b0;
    full_byte  = host_req.data;
    if (host_strobe && !host_req.read_n_write) begin
      if (four_bit_mode) begin // RQ25
        full_valid = nibble_phase_reg;
        full_byte  = {nibble_hold_reg, host_req.data[7:4]};
      end else begin
        full_valid = 1'b1;
      end
    end
  end

  // Writes arriving while busy are dropped, never queued
  assign accept = full_valid && (state_reg == lcd_decoder_pkg::ST_IDLE); // RQ16

  // Nibble pairing for writes.
  // The phase toggles on every write strobe, even one refused while busy,
  // so the pairing never slips against the host's own nibble count.
  // Limitation: only srst clears the phase; a width change leaves it as it is.
  always_ff @(posedge clock) begin
    if (srst) begin
      nibble_phase_reg <= 1'b0;
      nibble_hold_reg  <= 4'h0;
    end else if (clk_en) begin
      if (host_strobe && !host_req.read_n_write && four_bit_mode) begin // RQ7
        nibble_phase_reg <= ~nibble_phase_reg;
        nibble_hold_reg  <= host_req.data[7:4];
      end
    end
  end

  // Capture accepted instruction for execution after the busy window.
  // Holding a private copy lets the host bus go idle or change freely
  // while the instruction is still being worked on.
  // A data read records only its kind; the byte comes from the latch.
  always_ff @(posedge clock) begin
    if (srst) begin
      pend_rs_reg   <= 1'b0;
      pend_rw_reg   <= 1'b0;
      pend_data_reg <= 8'h00;
    end else if (clk_en && accept) begin
      pend_rs_reg   <= host_req.reg_select;
      pend_rw_reg   <= 1'b0;
      pend_data_reg <= full_byte;
    end else if (clk_en && host_strobe && host_req.read_n_write && host_req.reg_select
                 && state_reg == lcd_decoder_pkg::ST_IDLE && !rd_phase_reg) begin
      pend_rs_reg   <= 1'b1;
      pend_rw_reg   <= 1'b1;
    end
  end

  // Busy sequencer: flag stands from acceptance until the work is applied.
  // IDLE -> EXEC -> DONE steps one bit at a time; DONE -> IDLE flips both bits.
  // EXEC lasts EXEC_CYCLES cycles and DONE one more, in which work lands.
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg    <= lcd_decoder_pkg::ST_IDLE;
      exec_cnt_reg <= 8'h00;
    end else if (clk_en) begin
      case (state_reg)
        lcd_decoder_pkg::ST_IDLE: begin
          if (accept || data_read_go) begin // RQ26
            state_reg    <= lcd_decoder_pkg::ST_EXEC;
            exec_cnt_reg <= 8'(EXEC_CYCLES - 1);
          end
        end
        lcd_decoder_pkg::ST_EXEC: begin
          if (exec_cnt_reg == 8'h00) begin
            state_reg <= lcd_decoder_pkg::ST_DONE;
          end else begin
            exec_cnt_reg <= exec_cnt_reg - 8'h01;
          end
        end
        lcd_decoder_pkg::ST_DONE: state_reg <= lcd_decoder_pkg::ST_IDLE;
        default: state_reg <= lcd_decoder_pkg::ST_IDLE;
      endcase
    end
  end

  assign busy_flag = (state_reg != lcd_decoder_pkg::ST_IDLE); // RQ16

  // Apply carries the clock enable so a frozen clock also freezes the RAM
  assign apply = clk_en && (state_reg == lcd_decoder_pkg::ST_DONE);

  // A data read starts on the last transfer of the byte
  assign data_read_go = host_strobe && host_req.read_n_write && host_req.reg_select
                        && (state_reg == lcd_decoder_pkg::ST_IDLE)
                        && (!four_bit_mode || rd_phase_reg);

  // Opcode decode of the pending instruction; don't-care bits never looked at.
  // The opcode classes are told apart by their leading one, so at most one
  // of the instruction decodes is true for any pending byte.
  logic op_addr;
  logic op_contrast;
  logic op_func;
  logic op_shift;
  logic op_wr_data;
  logic op_rd_data;
  always_comb begin
    op_addr     = !pend_rs_reg && !pend_rw_reg
                  && pend_data_reg[lcd_decoder_pkg::ADDR_SET_BIT]; // RQ13
    op_contrast = !pend_rs_reg && !pend_rw_reg && pend_data_reg[7:6] == 2'b01; // RQ11
    op_func     = !pend_rs_reg && !pend_rw_reg && pend_data_reg[7:5] == 3'b001; // RQ6
    op_shift    = !pend_rs_reg && !pend_rw_reg && pend_data_reg[7:4] == 4'b0001; // RQ1
    op_wr_data  = pend_rs_reg && !pend_rw_reg; // RQ18
    op_rd_data  = pend_rs_reg && pend_rw_reg;
  end

  // Address stepping; line one end spills into line two start
  assign ac_up   = (addr_counter == lcd_decoder_pkg::LINE1_LAST)
                   ? lcd_decoder_pkg::LINE2_FIRST : addr_counter + 7'h01; // RQ3
  assign ac_down = addr_counter - 7'h01;
  // Cursor shift target follows its own direction bit, not the entry mode
  assign ac_cursor = pend_data_reg[lcd_decoder_pkg::SHIFT_RL_BIT] ? ac_up : ac_down;
  assign ac_step = entry_incr ? ac_up : ac_down; // RQ23
  assign is_text = addr_counter < lcd_decoder_pkg::TEXT_LIMIT; // RQ14

  // Address counter.
  // Only one source loads it per apply; priority follows the opcode decode.
  // Decrement below a line start is a plain minus one by design choice.
  always_ff @(posedge clock) begin
    if (srst) begin
      addr_counter <= lcd_decoder_pkg::AC_RESET;
    end else if (apply) begin
      if (op_addr) begin
        addr_counter <= pend_data_reg[6:0]; // RQ13
      end else if (op_shift && !pend_data_reg[lcd_decoder_pkg::SHIFT_SC_BIT]) begin
        addr_counter <= ac_cursor; // RQ2
      end else if (op_wr_data || op_rd_data) begin
        addr_counter <= ac_step; // RQ19 RQ22
      end
      // Display-only shift keeps the counter as it is (RQ5 holds by omission)
    end
  end

  // Display shift offset: one horizontal offset shared by all lines, taken
  // modulo the line length by the display scanner so no line spills upward
  always_ff @(posedge clock) begin
    if (srst) begin
      display_offset <= lcd_decoder_pkg::SHIFT_RESET;
    end else if (apply) begin
      if (op_shift && pend_data_reg[lcd_decoder_pkg::SHIFT_SC_BIT]) begin // RQ4 RQ5
        display_offset <= pend_data_reg[lcd_decoder_pkg::SHIFT_RL_BIT]
                          ? display_offset - 6'h01 : display_offset + 6'h01; // RQ2
      end else if (op_wr_data && entry_shift && is_text) begin // RQ19
        display_offset <= entry_incr ? display_offset + 6'h01 : display_offset - 6'h01;
      end
      // Reads never move the display
    end
  end

  // Function set and contrast.
  // Settings change only in the apply cycle, so the host sees the old
  // width until busy drops, and its next transfer uses the new one.
  always_ff @(posedge clock) begin
    if (srst) begin
      func_cfg.bus_width_sel  <= lcd_decoder_pkg::WIDTH_RESET;
      func_cfg.powerdown_n    <= lcd_decoder_pkg::PWR_RESET;
      func_cfg.contrast_level <= lcd_decoder_pkg::CONTRAST_RESET;
    end else if (apply) begin
      if (op_func) begin
        if (!serial_mode) begin
          func_cfg.bus_width_sel <= pend_data_reg[lcd_decoder_pkg::WIDTH_SEL_BIT]; // RQ6 RQ7
        end
        func_cfg.powerdown_n <= pend_data_reg[lcd_decoder_pkg::PWR_BIT]; // RQ8
      end
      if (op_contrast) begin
        func_cfg.contrast_level <= pend_data_reg[3:0]; // RQ11
      end
    end
  end

  // Display-on flag: powerdown forces it off and only a display-on command
  // raises it again; RAM is untouched so text returns at once
  always_ff @(posedge clock) begin
    if (srst) begin
      display_on <= 1'b0;
    end else if (clk_en) begin
      if (apply && op_func && !pend_data_reg[lcd_decoder_pkg::PWR_BIT]) begin
        display_on <= 1'b0; // RQ9
      end else if (display_on_set) begin
        display_on <= display_on_val; // RQ24
      end
    end
  end

  // RAM write; glyph and icon words keep only five bits.
  // No reset: contents survive powerdown and display-off alike,
  // and clearing 128 words in one edge would cost far too much logic.
  always_ff @(posedge clock) begin
    if (apply && op_wr_data) begin
      ram_mem[addr_counter] <= is_text ? pend_data_reg
                                       : {3'h0, pend_data_reg[4:0]}; // RQ18
    end
  end

  // Read latch: loaded on address set, cursor shift and data read, not on a data write, so a read right after
  // a write returns the pre-write latch, which the host must discard
  always_ff @(posedge clock) begin
    if (srst) begin
      read_latch_reg <= 8'h00;
    end else if (apply && (op_addr || (op_shift && !pend_data_reg[3]) || op_rd_data)) begin
      read_latch_reg <= ram_mem[op_addr  ? pend_data_reg[6:0]
                              : op_shift ? ac_cursor : ac_step]; // RQ20 RQ21
    end
  end

  // Read path: status or data, split into two nibbles in four-bit mode.
  // The whole byte is frozen on the first nibble, so a status value never
  // tears between its two halves even if busy drops in between.
  // Status reads are answered at any time, busy or not.
  always_ff @(posedge clock) begin
    if (srst) begin
      rd_phase_reg <= 1'b0;
      rd_byte_reg  <= 8'h00;
      host_rdata   <= 8'h00;
    end else if (clk_en && host_strobe && host_req.read_n_write) begin
      if (four_bit_mode && rd_phase_reg) begin
        host_rdata   <= {rd_byte_reg[3:0], 4'h0}; // RQ25
        rd_phase_reg <= 1'b0;
      end else begin
        rd_byte_reg <= host_req.reg_select ? read_latch_reg
                                           : {busy_flag, addr_counter}; // RQ15 RQ20
        host_rdata  <= host_req.reg_select ? read_latch_reg
                                           : {busy_flag, addr_counter};
        rd_phase_reg <= four_bit_mode;
      end
    end
  end

endmodule : lcd_instruction_decoder

/* lcd_instruction_decoder_ram_access_tb_top.sv */
// Self-checking bench for the LCD instruction decoder with a host model.
// Assumes a 125 MHz clock and a short execution time for speed.
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module lcd_instruction_decoder_ram_access_tb_top;
  logic clock = 1'b0, srst = 1'b1, serial_mode = 1'b0, entry_incr = 1'b1, entry_shift = 1'b0;
  logic display_on_set = 1'b0, display_on_val = 1'b0, host_strobe, busy_flag, display_on, fbm;
  lcd_decoder_pkg::host_req_s host_req;
  lcd_decoder_pkg::func_cfg_s func_cfg;
  logic [7:0] host_rdata, b;
  logic [6:0] addr_counter, a;
  logic [5:0] display_offset;
  int         mismatches = 0, checked = 0, seed;
  // Free-running clock
  always #4 clock = ~clock;
  lcd_instruction_decoder #(.EXEC_CYCLES(1)) i_lcd_instruction_decoder (
    .clock(clock), .srst(srst), .clk_en(1'b1), .serial_mode(serial_mode),
    .host_strobe(host_strobe), .host_req(host_req), .host_rdata(host_rdata),
    .entry_incr(entry_incr), .entry_shift(entry_shift), .display_on_set(display_on_set),
    .display_on_val(display_on_val), .busy_flag(busy_flag), .addr_counter(addr_counter),
    .func_cfg(func_cfg), .display_on(display_on), .display_offset(display_offset),
    .four_bit_mode(fbm));
  lcd_host_model i_lcd_host_model (.clock(clock), .busy_flag(busy_flag),
    .host_strobe(host_strobe), .host_req(host_req));
  function automatic logic [6:0] step(input logic [6:0] v, input logic up);
    return up ? ((v == 7'h0f) ? 7'h10 : v + 7'h01) : v - 7'h01;
  endfunction : step
  // Glyph and icon words keep only five bits
  function automatic logic [7:0] ram_view(input logic [6:0] ad, input logic [7:0] v);
    return (ad < 7'h30) ? v : {3'h0, v[4:0]};
  endfunction : ram_view
  task automatic op(input logic rs, input logic rw, input logic [7:0] d);
    i_lcd_host_model.send(rs, rw, d);
    i_lcd_host_model.wait_idle();
  endtask : op
  task automatic complete_run();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  // Watchdog far beyond the expected run length
  initial begin
    #400000;
    mismatches++;
    complete_run();
  end
  // Main sequence
  initial begin
    seed = $urandom(32'h84de);
    repeat (6) @(negedge clock);
    srst = 1'b0;
    `CHK({busy_flag, addr_counter, func_cfg, display_on, fbm}, 16'h00c0)
    op(1'b0, 1'b0, 8'h31);
    for (int k = 0; k < 4; k++) begin
      a = 7'($urandom);
      op(1'b0, 1'b0, {1'b1, a});
      `CHK(addr_counter, a)
      op(1'b0, 1'b0, {4'h1, 2'(k), 2'($urandom)});
      `CHK(addr_counter, k[1] ? a : step(a, k[0]))
    end
    `CHK(display_offset, 6'h00)
    op(1'b0, 1'b0, 8'h8f);
    op(1'b0, 1'b0, {6'h05, 2'($urandom)});
    `CHK(addr_counter, 7'h10)
    // Refused instruction and status read while busy
    i_lcd_host_model.send(1'b0, 1'b0, 8'h85);
    i_lcd_host_model.send(1'b0, 1'b0, 8'h9a);
    i_lcd_host_model.wait_idle();
    `CHK(addr_counter, 7'h05)
    i_lcd_host_model.send(1'b0, 1'b0, 8'h47);
    i_lcd_host_model.send(1'b0, 1'b1, 8'h00);
    `CHK(host_rdata[7], 1'b1)
    i_lcd_host_model.wait_idle();
    op(1'b0, 1'b1, 8'h00);
    `CHK(host_rdata, 8'h05)
    for (int k = 0; k < 16; k++) begin
      op(1'b0, 1'b0, {2'b01, 2'($urandom), 4'(k)});
      `CHK(func_cfg.contrast_level, 4'(k))
    end
    // Random RAM traffic across text, glyph and icon regions
    for (int k = 0; k < 16; k++) begin
      a = 7'($urandom);
      if (a[6:4] == 3'h3) a[6] = 1'b1;
      b = 8'($urandom);
      entry_incr = 1'($urandom);
      op(1'b0, 1'b0, {1'b1, a});
      op(1'b1, 1'b0, b);
      `CHK(addr_counter, step(a, entry_incr))
      op(1'b0, 1'b0, {1'b1, a});
      op(1'b1, 1'b1, 8'h00);
      `CHK(host_rdata, ram_view(a, b))
      `CHK(addr_counter, step(a, entry_incr))
    end
    entry_shift = 1'b1;
    op(1'b0, 1'b0, 8'ha0);
    op(1'b1, 1'b1, 8'h00);
    `CHK(display_offset, 6'h00)
    op(1'b1, 1'b0, 8'h41);
    `CHK(display_offset != 6'h00, 1'b1)
    entry_shift = 1'b0;
    // Powerdown turns the display off and keeps it off
    display_on_val = 1'b1;
    display_on_set = 1'b1;
    @(negedge clock);
    display_on_set = 1'b0;
    op(1'b0, 1'b0, 8'h30);
    `CHK({display_on, func_cfg.powerdown_n}, 2'b00)
    op(1'b0, 1'b0, 8'h31);
    `CHK({display_on, func_cfg.powerdown_n}, 2'b01)
    // Width select, serial override and four-bit transfers
    serial_mode = 1'b1;
    op(1'b0, 1'b0, 8'h21);
    `CHK(fbm, 1'b0)
    serial_mode = 1'b0;
    op(1'b0, 1'b0, 8'h21);
    `CHK(fbm, 1'b1)
    i_lcd_host_model.send(1'b0, 1'b0, {4'h9, 4'($urandom)});
    op(1'b0, 1'b0, {4'h5, 4'($urandom)});
    `CHK(addr_counter, 7'h15)
    op(1'b0, 1'b1, 8'h00);
    `CHK(host_rdata[7:4], 4'h1)
    op(1'b0, 1'b1, 8'h00);
    `CHK(host_rdata[7:4], 4'h5)
    i_lcd_host_model.send(1'b0, 1'b0, {4'h3, 4'($urandom)});
    op(1'b0, 1'b0, {4'h1, 4'($urandom)});
    `CHK(fbm, 1'b0)
    op(1'b0, 1'b0, 8'h40);
    complete_run();
  end
endmodule : lcd_instruction_decoder_ram_access_tb_top
